// File: hdl/epd_pkg.sv
package epd_pkg;

  localparam int EPD_SEL_W = 5;
  localparam int EPD_CNT_W = 6;
  localparam logic [EPD_SEL_W-1:0] EPD_SEL_MIN = 5'h02;
  localparam logic [EPD_CNT_W-1:0] EPD_CNT_ZERO = 6'h00;
  localparam logic [EPD_CNT_W-1:0] EPD_CNT_ONE = 6'h01;
  localparam logic [1:0] EPD_QUAD_ZERO = 2'h0;
  localparam logic [1:0] EPD_QUAD_ONE = 2'h1;
  localparam logic [1:0] EPD_QUAD_MINUS = 2'h3;

  typedef enum logic
  {
    EPD_VARIANT_OC,
    EPD_VARIANT_DIFF
  } epd_variant_t;

  typedef struct packed
  {
    logic phase_a;
    logic phase_b;
    logic index_z;
  } epd_phase_t;

  typedef struct packed
  {
    logic divided_phase_a_oc_out;
    logic divided_phase_b_oc_out;
    logic divided_phase_a_pos;
    logic divided_phase_a_neg;
    logic divided_phase_b_pos;
    logic divided_phase_b_neg;
    logic divided_index_pos;
    logic divided_index_neg;
  } epd_out_t;

  typedef struct packed
  {
    epd_phase_t sync1;
    epd_phase_t sync2;
    epd_phase_t prev;
    logic [1:0] mode_sync1;
    logic [1:0] mode_sync2;
    logic [EPD_SEL_W-1:0] sel_sync1;
    logic [EPD_SEL_W-1:0] sel_sync2;
    logic [EPD_CNT_W-1:0] edge_cnt;
    logic [1:0] out_quad;
    logic out_index;
    logic active;
  } epd_state_t;

endpackage

// File: hdl/epd_encoder_pulse_divider.sv
// Behaviour
// R01 - Output frequency is input over twice switch value; values 0 and 1 give none.
// R02 - Switch read as 5-bit unsigned, position 1 most significant, all on is 31.
// R03 - In pulse-direction mode phase A carries pulses and phase B the direction.
// R04 - Quadrature mode by default; pulse-direction only when the mode jumpers select it.
// R05 - Open-collector variant drives divided A and B only, no divided index.
// R06 - Differential variant drives divided A, B and Z as complementary pairs.
// R07 - Divided A and B keep quadrature phase, so direction stays visible.
`timescale 1ns/1ps
`default_nettype none

module epd_encoder_pulse_divider
  import epd_pkg::*;
#(
  parameter epd_variant_t VARIANT = EPD_VARIANT_DIFF
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire epd_phase_t phase_i,
  input wire logic [EPD_SEL_W-1:0] divider_select_switch_i,
  input wire logic input_mode_jumper_a_i,
  input wire logic input_mode_jumper_b_i,
  output var epd_out_t out_o,
  output logic divided_active_o
);

  epd_state_t state_ff;
  epd_state_t nxt_state;

  // Returns the signed step of one quadrature transition, zero when none or invalid.
  function automatic logic [1:0] quad_step(input logic [1:0] old_ab, input logic [1:0] new_ab);
    logic [1:0] res;
    res = EPD_QUAD_ZERO;
    case ({old_ab, new_ab})
      4'h1, 4'h7, 4'he, 4'h8: res = EPD_QUAD_MINUS; // [R07]
      4'h2, 4'hb, 4'hd, 4'h4: res = EPD_QUAD_ONE; // [R07]
      default: res = EPD_QUAD_ZERO;
    endcase
    return res;
  endfunction

  logic pulse_mode;
  logic [1:0] step;
  logic [EPD_CNT_W-1:0] limit;
  logic [EPD_CNT_W-1:0] cnt_plus;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.sync1 = phase_i;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev = state_ff.sync2;
    nxt_state.mode_sync1 = {input_mode_jumper_a_i, input_mode_jumper_b_i};
    nxt_state.mode_sync2 = state_ff.mode_sync1;
    nxt_state.sel_sync1 = divider_select_switch_i; // [R02]
    nxt_state.sel_sync2 = state_ff.sel_sync1;
    pulse_mode = &state_ff.mode_sync2; // [R04]
    nxt_state.active = (state_ff.sel_sync2 >= EPD_SEL_MIN); // [R01]
    // Quadrature yields four steps per input period and pulse mode two.
    if (pulse_mode)
    begin
      limit = {1'b0, state_ff.sel_sync2}; // [R03]
    end
    else
    begin
      limit = {state_ff.sel_sync2, 1'b0}; // [R01]
    end
    cnt_plus = state_ff.edge_cnt + EPD_CNT_ONE;
    step = EPD_QUAD_ZERO;
    if (pulse_mode)
    begin
      // Both edges of each pulse count, so one pulse is two steps.
      if (state_ff.sync2.phase_a != state_ff.prev.phase_a)
      begin
        step = state_ff.sync2.phase_b ? EPD_QUAD_MINUS : EPD_QUAD_ONE; // [R03]
      end
    end
    else
    begin
      step = quad_step({state_ff.prev.phase_a, state_ff.prev.phase_b},
                       {state_ff.sync2.phase_a, state_ff.sync2.phase_b});
    end
    if (!state_ff.active)
    begin
      nxt_state.edge_cnt = EPD_CNT_ZERO;
      nxt_state.out_quad = EPD_QUAD_ZERO;
    end
    else if (state_ff.edge_cnt >= limit)
    begin
      // A lowered limit must not leave the count stranded above it.
      nxt_state.edge_cnt = EPD_CNT_ZERO;
    end
    else if (step != EPD_QUAD_ZERO)
    begin
      // Four quarters of limit steps each make one period of twice sel input periods.
      if (cnt_plus >= limit) // [R01]
      begin
        nxt_state.edge_cnt = EPD_CNT_ZERO;
        nxt_state.out_quad = state_ff.out_quad + step; // [R07]
      end
      else
      begin
        nxt_state.edge_cnt = cnt_plus;
      end
    end
    nxt_state.out_index = state_ff.active && state_ff.sync2.index_z && !pulse_mode;
    if (!rst_n_i)
    begin
      nxt_state = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state_ff <= nxt_state;
  end

  logic div_a;
  logic div_b;
  assign div_a = state_ff.out_quad[1] ^ state_ff.out_quad[0]; // [R07]
  assign div_b = state_ff.out_quad[1];
  assign divided_active_o = state_ff.active;

  always_comb
  begin
    out_o = '0;
    if (VARIANT == EPD_VARIANT_OC)
    begin
      out_o.divided_phase_a_oc_out = div_a; // [R05]
      out_o.divided_phase_b_oc_out = div_b; // [R05]
    end
    else
    begin
      out_o.divided_phase_a_pos = div_a; // [R06]
      out_o.divided_phase_a_neg = !div_a;
      out_o.divided_phase_b_pos = div_b; // [R06]
      out_o.divided_phase_b_neg = !div_b;
      out_o.divided_index_pos = state_ff.out_index; // [R06]
      out_o.divided_index_neg = !state_ff.out_index;
    end
  end

  no_output_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R01]
    !state_ff.active |=> state_ff.out_quad == EPD_QUAD_ZERO && state_ff.edge_cnt == EPD_CNT_ZERO)
    else $error("divided output moved while off");

  quad_gray_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R07]
    $past(state_ff.active) |-> !($changed(div_a) && $changed(div_b)))
    else $error("divided phases changed together");

  oc_no_index_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R05]
    VARIANT == EPD_VARIANT_OC |-> !out_o.divided_index_pos && !out_o.divided_index_neg)
    else $error("index driven on open-collector variant");

  oc_no_diff_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R05]
    VARIANT == EPD_VARIANT_OC |-> !out_o.divided_phase_a_pos && !out_o.divided_phase_a_neg
    && !out_o.divided_phase_b_pos && !out_o.divided_phase_b_neg)
    else $error("differential output driven on open-collector variant");

  diff_pair_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
    VARIANT == EPD_VARIANT_DIFF |-> out_o.divided_phase_a_pos != out_o.divided_phase_a_neg
    && out_o.divided_phase_b_pos != out_o.divided_phase_b_neg)
    else $error("differential pair not complementary");

  index_pair_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
    VARIANT == EPD_VARIANT_DIFF |-> out_o.divided_index_pos != out_o.divided_index_neg)
    else $error("index pair not complementary");

  diff_no_oc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
    VARIANT == EPD_VARIANT_DIFF |-> !out_o.divided_phase_a_oc_out
    && !out_o.divided_phase_b_oc_out)
    else $error("open-collector output driven on differential variant");

  sel_active_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R02]
    state_ff.sel_sync2 < EPD_SEL_MIN |=> !state_ff.active)
    else $error("active with low switch");

  sel_on_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R01]
    state_ff.sel_sync2 >= EPD_SEL_MIN |=> state_ff.active)
    else $error("inactive with divider switch set");

  cnt_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R01]
    state_ff.active && $stable(limit) |-> state_ff.edge_cnt < limit)
    else $error("edge count beyond limit");

  out_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R01]
    state_ff.active && step == EPD_QUAD_ZERO |=> $stable(state_ff.out_quad))
    else $error("divided output moved without input step");

  quad_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R04]
    !pulse_mode && state_ff.active && step == EPD_QUAD_ZERO && state_ff.edge_cnt < limit
    |=> $stable(state_ff.edge_cnt))
    else $error("count moved without input edge");

  step_valid_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R07]
    step == EPD_QUAD_ZERO || step == EPD_QUAD_ONE || step == EPD_QUAD_MINUS)
    else $error("step larger than one quarter");

  fwd_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R07]
    state_ff.active && step == EPD_QUAD_ONE
    |=> state_ff.out_quad - $past(state_ff.out_quad) != EPD_QUAD_MINUS)
    else $error("forward step moved output backward");

  rev_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R07]
    state_ff.active && step == EPD_QUAD_MINUS
    |=> state_ff.out_quad - $past(state_ff.out_quad) != EPD_QUAD_ONE)
    else $error("reverse step moved output forward");

  pulse_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R03]
    pulse_mode && state_ff.sync2.phase_a == state_ff.prev.phase_a |-> step == EPD_QUAD_ZERO)
    else $error("step without pulse edge");

  pulse_rev_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R03]
    pulse_mode && state_ff.sync2.phase_b |-> step != EPD_QUAD_ONE)
    else $error("forward step with direction high");

  pulse_fwd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R03]
    pulse_mode && !state_ff.sync2.phase_b |-> step != EPD_QUAD_MINUS)
    else $error("reverse step with direction low");

  index_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
    pulse_mode || !state_ff.active |=> !state_ff.out_index)
    else $error("index passed while gated");

endmodule

`default_nettype wire

// File: test/epd_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module epd_source_model
  import epd_pkg::*;
(
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic rev_i,
  input wire logic pulse_i,
  output var epd_phase_t phase_o
);
  logic [1:0] q_ff = 2'h0;
  logic [1:0] t_ff = 2'h0;
  always_ff @(posedge clk_i)
  begin
    t_ff <= (t_ff == 2'h2) ? 2'h0 : t_ff + 2'h1;
    if (run_i && t_ff == 2'h0)
      q_ff <= rev_i ? q_ff - 2'h1 : q_ff + 2'h1;
  end
  assign phase_o.phase_a = pulse_i ? q_ff[0] : q_ff[1] ^ q_ff[0];
  assign phase_o.phase_b = pulse_i ? rev_i : q_ff[1];
  assign phase_o.index_z = (q_ff == 2'h2) & ~pulse_i;
endmodule
`default_nettype wire

// File: test/test_encoder_pulse_divider.sv
`timescale 1ns/1ps
`default_nettype none
module test_encoder_pulse_divider;
  import epd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] sw = 5'h00;
  logic [1:0] jmp = 2'h0;
  logic rev = 1'b0;
  logic go = 1'b0;
  logic seen = 1'b0;
  logic a_q = 1'b0;
  logic pa_q = 1'b0;
  logic [6:0] per = 7'h00;
  logic [6:0] nt;
  logic [6:0] note[$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 12640;
  epd_phase_t ph;
  epd_out_t od;
  epd_out_t oo;
  logic act;
  initial forever #12.5 clk_i = ~clk_i;
  epd_source_model src (.clk_i(clk_i), .run_i(go), .rev_i(rev), .pulse_i(&jmp), .phase_o(ph));
  epd_encoder_pulse_divider #(.VARIANT(EPD_VARIANT_DIFF)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .phase_i(ph), .divider_select_switch_i(sw), .input_mode_jumper_a_i(jmp[1]),
    .input_mode_jumper_b_i(jmp[0]), .out_o(od), .divided_active_o(act));
  epd_encoder_pulse_divider #(.VARIANT(EPD_VARIANT_OC)) uut_oc (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .phase_i(ph), .divider_select_switch_i(sw), .input_mode_jumper_a_i(jmp[1]),
    .input_mode_jumper_b_i(jmp[0]), .out_o(oo), .divided_active_o());
  task automatic results();
    $display("errors %0d check_count %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Intervals between divided A rises are counted in input A rises.
  always @(negedge clk_i)
  begin
    a_q <= od.divided_phase_a_pos;
    pa_q <= ph.phase_a;
    per <= per + 7'(ph.phase_a & ~pa_q);
    if (od.divided_phase_a_pos & ~a_q)
    begin
      per <= 7'(ph.phase_a & ~pa_q);
      seen <= 1'b1;
      if (seen && note.size() > 0)
      begin
        nt = note.pop_front();
        check("periods", {2'h0, nt[5:0]}, {1'b0, per});
        check("direction", {7'h0, nt[6]}, {7'h0, od.divided_phase_b_pos});
        check("pairs", 8'he0, {od.divided_phase_a_pos ^ od.divided_phase_a_neg,
          od.divided_phase_b_pos ^ od.divided_phase_b_neg,
          od.divided_index_pos ^ od.divided_index_neg,
          oo.divided_phase_a_oc_out ^ od.divided_phase_a_pos,
          oo.divided_phase_b_oc_out ^ od.divided_phase_b_pos, oo.divided_index_pos,
          oo.divided_index_neg, oo.divided_phase_a_pos});
      end
    end
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      results();
    end
  end
  task automatic run(input int s, input logic [1:0] j, input logic rv);
    int n;
    sw <= 5'(s);
    jmp <= j;
    rev <= rv;
    repeat (8) @(posedge clk_i);
    seen <= 1'b0;
    go <= 1'b1;
    for (n = 0; n < 2 && s > 1; n++) note.push_back({rv, 6'(2 * s)});
    repeat (96 * s + 60) @(posedge clk_i);
    go <= 1'b0;
    check("active", {7'h0, s > 1}, {7'h0, act});
    check("missing", 8'h00, 8'(note.size()));
    note.delete();
    repeat (12) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    run(0, 2'h0, 1'b0);
    run(1, 2'h3, 1'b0);
    run(2, 2'h0, 1'b0);
    run(2, 2'h0, 1'b1);
    run(31, 2'h2, 1'b0);
    run(3, 2'h3, 1'b0);
    run(3, 2'h3, 1'b1);
    run(16, 2'h1, 1'b1);
    repeat (3) run(2 + $unsigned($random(seed)) % 30, 2'($random(seed)), 1'($random(seed)));
    results();
  end
endmodule
`default_nettype wire
